/* File: include/adcs_pkg.sv */
// constants, types and register map of the converter channel sequencer
// Behaviour
// - twelve-bit results, under 0.55 Msps aggregate rate at the 10 MHz clock (18 converter clocks plus sampling per result)
// - converter clock under 18 MHz, 18 clocks/conversion
// - eight-input channel selector drives the converter
// - scan steps enabled channels with no gaps
// - channel picked by sequencer or by firmware
// - one result buffer per channel
// - per-channel sample time applied on each conversion
// - each result checked against limits, interrupt at once
// - sample aperture length programmable
// - sequencer halted in deepest low-power mode
package adcs_pkg;
    // ****************************************************************
    // sizes and timing
    // ****************************************************************
    localparam int RES_W = 12;
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int SMP_W = 8;
    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_CLK_MAX_HZ = 18_000_000;
    localparam int CONV_DIV = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
    localparam logic [7:0] CONV_CLKS = 8'h12;
    localparam logic [SMP_W-1:0] SMP_RST = 8'h04;
    localparam logic [SMP_W-1:0] SMP_MIN = 8'h01;
    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CHEN = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_IRQ = 8'h0C;
    localparam logic [7:0] A_MASK = 8'h10;
    localparam logic [7:0] A_LIM = 8'h14;
    localparam logic [7:0] A_RFLAG = 8'h18;
    localparam logic [7:0] A_SMP = 8'h20;
    localparam logic [7:0] A_RES = 8'h40;
    localparam int WIN_HI = 7;
    localparam int WIN_LO = 5;
    localparam int IDX_HI = 4;
    localparam int IDX_LO = 2;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int C_EN = 0;
    localparam int C_FW = 1;
    localparam int C_CONT = 2;
    localparam int C_START = 3;
    localparam int C_FWCH = 4;
    localparam int S_BUSY = 0;
    localparam int S_CH = 1;
    localparam int S_DEEP = 4;
    localparam int L_HI = 16;
    localparam int R_VALID = 31;
    localparam int I_RANGE = 0;
    localparam int I_EOC = 1;
    localparam int I_SCAN = 2;
    localparam int NIRQ = 3;
    localparam logic [RES_W-1:0] LIM_HI_RST = 12'hFFF;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_WAIT = 4'b1000
    } adcs_state_e;

    typedef struct packed {
        logic [CH_W-1:0] mux_sel;
        logic sample;
        logic convert;
    } adcs_core_req_s;

    typedef struct packed {
        logic valid;
        logic [RES_W-1:0] data;
    } adcs_core_rsp_s;
endpackage : adcs_pkg

/* File: verilog/adcs_tick.sv */
// converter clock enable divider
`timescale 1ns/100ps
`default_nettype none
module adcs_tick #(
    parameter int DIV = adcs_pkg::CONV_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control and enable out
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } adcs_tick_s;

    localparam logic [7:0] LAST = 8'(DIV - 1);

    adcs_tick_s s_r;
    adcs_tick_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run)
        begin
            s_nxt.cnt = '0;
        end
        else if (s_r.cnt >= LAST)
        begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick = s_r.tick;
endmodule : adcs_tick
`default_nettype wire

/* File: verilog/adcs_pick.sv */
// next enabled channel after the current one, wrapping
`timescale 1ns/100ps
`default_nettype none
module adcs_pick (
    // search input
    input wire logic [adcs_pkg::CH_W-1:0] cur,
    input wire logic [adcs_pkg::NCH-1:0] en,
    // result
    output logic [adcs_pkg::CH_W-1:0] nxt,
    output logic found,
    output logic wrap
);
    always_comb
    begin
        logic [adcs_pkg::CH_W-1:0] idx;
        idx = '0;
        nxt = cur;
        found = 1'b0;
        // search farthest first so the nearest hit is assigned last and kept, so scan order is ascending
        for (int i = adcs_pkg::NCH; i >= 1; i--)
        begin
            idx = cur + adcs_pkg::CH_W'(i);
            if (en[idx])
            begin
                nxt = idx;
                found = 1'b1;
            end
        end
        wrap = found && (nxt <= cur);
    end
endmodule : adcs_pick
`default_nettype wire

/* File: verilog/adcs_seq.sv */
// converter channel sequencer with APB registers
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adcs_seq #(
    parameter int DIV = adcs_pkg::CONV_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter core
    output adcs_pkg::adcs_core_req_s core_req,
    output logic core_tick,
    input wire adcs_pkg::adcs_core_rsp_s core_rsp,
    // power and interrupt
    input wire logic deep_sleep,
    output logic irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        adcs_pkg::adcs_state_e st;
        logic [7:0] cnt;
        logic [adcs_pkg::CH_W-1:0] ch;
        logic start;
        logic en;
        logic fw_mode;
        logic cont;
        logic [adcs_pkg::CH_W-1:0] fw_ch;
        logic [adcs_pkg::NCH-1:0] chen;
        logic [adcs_pkg::RES_W-1:0] lim_lo;
        logic [adcs_pkg::RES_W-1:0] lim_hi;
        logic [adcs_pkg::NCH-1:0][adcs_pkg::SMP_W-1:0] smp;
        logic [adcs_pkg::NCH-1:0][adcs_pkg::RES_W-1:0] res;
        logic [adcs_pkg::NCH-1:0] rvalid;
        logic [adcs_pkg::NCH-1:0] rflag;
        logic [adcs_pkg::NIRQ-1:0] stat;
        logic [adcs_pkg::NIRQ-1:0] mask;
        adcs_pkg::adcs_core_req_s req;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } adcs_seq_s;

    adcs_seq_s s_r;
    adcs_seq_s s_nxt;
    logic tick;
    logic [adcs_pkg::CH_W-1:0] pk_cur;
    logic [adcs_pkg::CH_W-1:0] pk_nxt;
    logic pk_found;
    logic pk_wrap;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [adcs_pkg::SMP_W-1:0] smp_len(
        input logic [adcs_pkg::SMP_W-1:0] v
    );
        smp_len = (v < adcs_pkg::SMP_MIN) ? adcs_pkg::SMP_MIN : v;
    endfunction : smp_len

    function automatic logic out_of_range(
        input logic [adcs_pkg::RES_W-1:0] v,
        input logic [adcs_pkg::RES_W-1:0] lo,
        input logic [adcs_pkg::RES_W-1:0] hi
    );
        out_of_range = (v < lo) || (v > hi);
    endfunction : out_of_range

    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
        in_win = (a[adcs_pkg::WIN_HI:adcs_pkg::WIN_LO]
                  == base[adcs_pkg::WIN_HI:adcs_pkg::WIN_LO]);
    endfunction : in_win

    // ****************************************************************
    // submodules
    // ****************************************************************
    adcs_tick #(.DIV(DIV)) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(s_nxt.st != adcs_pkg::ST_IDLE),
        .tick(tick)
    );

    // scan from the top channel when idle so the first pick is the lowest
    assign pk_cur = (s_r.st == adcs_pkg::ST_IDLE) ? '1 : s_r.ch;

    adcs_pick u_pick (
        .cur(pk_cur),
        .en(s_r.chen),
        .nxt(pk_nxt),
        .found(pk_found),
        .wrap(pk_wrap)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic acc;
        logic wr_go;
        logic rd_go;
        logic hit;
        logic [31:0] rd;
        logic [adcs_pkg::CH_W-1:0] idx;
        logic [adcs_pkg::NIRQ-1:0] ev;
        logic [adcs_pkg::CH_W-1:0] go_ch;
        logic go;
        acc = psel && penable;
        wr_go = acc && s_r.pready && pwrite;
        rd_go = acc && s_r.pready && !pwrite;
        idx = paddr[adcs_pkg::IDX_HI:adcs_pkg::IDX_LO];
        ev = '0;
        go = 1'b0;
        go_ch = s_r.fw_ch;
        hit = 1'b1;
        rd = '0;
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;

        // register read mux
        if (in_win(paddr, adcs_pkg::A_SMP))
            rd[adcs_pkg::SMP_W-1:0] = s_r.smp[idx];
        else if (in_win(paddr, adcs_pkg::A_RES))
        begin
            rd[adcs_pkg::RES_W-1:0] = s_r.res[idx];
            rd[adcs_pkg::R_VALID] = s_r.rvalid[idx];
        end
        else
        begin
            case (paddr)
                adcs_pkg::A_CTRL:
                begin
                    rd[adcs_pkg::C_EN] = s_r.en;
                    rd[adcs_pkg::C_FW] = s_r.fw_mode;
                    rd[adcs_pkg::C_CONT] = s_r.cont;
                    rd[adcs_pkg::C_START] = s_r.start;
                    rd[adcs_pkg::C_FWCH +: adcs_pkg::CH_W] = s_r.fw_ch;
                end
                adcs_pkg::A_CHEN: rd[adcs_pkg::NCH-1:0] = s_r.chen;
                adcs_pkg::A_STAT:
                begin
                    rd[adcs_pkg::S_BUSY] = (s_r.st != adcs_pkg::ST_IDLE);
                    rd[adcs_pkg::S_CH +: adcs_pkg::CH_W] = s_r.ch;
                    rd[adcs_pkg::S_DEEP] = deep_sleep;
                end
                adcs_pkg::A_IRQ: rd[adcs_pkg::NIRQ-1:0] = s_r.stat;
                adcs_pkg::A_MASK: rd[adcs_pkg::NIRQ-1:0] = s_r.mask;
                adcs_pkg::A_LIM:
                begin
                    rd[adcs_pkg::RES_W-1:0] = s_r.lim_lo;
                    rd[adcs_pkg::L_HI +: adcs_pkg::RES_W] = s_r.lim_hi;
                end
                adcs_pkg::A_RFLAG: rd[adcs_pkg::NCH-1:0] = s_r.rflag;
                default: hit = 1'b0;
            endcase
        end

        // one wait state: data and error are registered in the same cycle as pready
        if (acc && !s_r.pready)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = rd;
            s_nxt.pslverr = !hit;
        end

        // software side effects first, so hardware sets below win
        if (rd_go && in_win(paddr, adcs_pkg::A_RES))
            s_nxt.rvalid[idx] = 1'b0;
        if (wr_go)
        begin
            if (in_win(paddr, adcs_pkg::A_SMP))
                s_nxt.smp[idx] = pwdata[adcs_pkg::SMP_W-1:0];
            else
            begin
                case (paddr)
                    adcs_pkg::A_CTRL:
                    begin
                        s_nxt.en = pwdata[adcs_pkg::C_EN];
                        s_nxt.fw_mode = pwdata[adcs_pkg::C_FW];
                        s_nxt.cont = pwdata[adcs_pkg::C_CONT];
                        s_nxt.fw_ch = pwdata[adcs_pkg::C_FWCH +: adcs_pkg::CH_W];
                        if (pwdata[adcs_pkg::C_START])
                            s_nxt.start = 1'b1;
                    end
                    adcs_pkg::A_CHEN: s_nxt.chen = pwdata[adcs_pkg::NCH-1:0];
                    adcs_pkg::A_IRQ: s_nxt.stat = s_r.stat & ~pwdata[adcs_pkg::NIRQ-1:0];
                    adcs_pkg::A_MASK: s_nxt.mask = pwdata[adcs_pkg::NIRQ-1:0];
                    adcs_pkg::A_LIM:
                    begin
                        s_nxt.lim_lo = pwdata[adcs_pkg::RES_W-1:0];
                        s_nxt.lim_hi = pwdata[adcs_pkg::L_HI +: adcs_pkg::RES_W];
                    end
                    adcs_pkg::A_RFLAG: s_nxt.rflag = s_r.rflag & ~pwdata[adcs_pkg::NCH-1:0];
                    default: ;
                endcase
            end
        end

        // sequencer
        case (s_r.st)
            adcs_pkg::ST_IDLE:
            begin
                if (s_r.start && s_r.en && !deep_sleep)
                begin
                    if (s_r.fw_mode)
                        go = 1'b1;
                    else if (pk_found)
                    begin
                        go = 1'b1;
                        go_ch = pk_nxt;
                    end
                    else
                        s_nxt.start = 1'b0;
                end
            end
            adcs_pkg::ST_SAMPLE:
            begin
                if (tick)
                begin
                    if (s_r.cnt <= adcs_pkg::SMP_MIN)
                    begin
                        s_nxt.st = adcs_pkg::ST_CONVERT;
                        s_nxt.cnt = adcs_pkg::CONV_CLKS;
                        s_nxt.req.sample = 1'b0;
                        s_nxt.req.convert = 1'b1;
                    end
                    else
                        s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            adcs_pkg::ST_CONVERT:
            begin
                if (tick)
                begin
                    if (s_r.cnt <= adcs_pkg::SMP_MIN)
                    begin
                        s_nxt.st = adcs_pkg::ST_WAIT;
                        s_nxt.req.convert = 1'b0;
                    end
                    else
                        s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            adcs_pkg::ST_WAIT:
            begin
                if (core_rsp.valid)
                begin
                    s_nxt.res[s_r.ch] = core_rsp.data;
                    s_nxt.rvalid[s_r.ch] = 1'b1;
                    ev[adcs_pkg::I_EOC] = 1'b1;
                    if (out_of_range(core_rsp.data, s_r.lim_lo, s_r.lim_hi))
                    begin
                        ev[adcs_pkg::I_RANGE] = 1'b1;
                        s_nxt.rflag[s_r.ch] = 1'b1;
                    end
                    s_nxt.st = adcs_pkg::ST_IDLE;
                    s_nxt.start = 1'b0;
                    if (s_r.fw_mode)
                    begin
                        if (s_r.cont && s_r.en)
                        begin
                            go = 1'b1;
                            s_nxt.start = 1'b1;
                        end
                    end
                    else if (pk_found)
                    begin
                        ev[adcs_pkg::I_SCAN] = pk_wrap;
                        // straight into the next channel's sampling
                        if (s_r.en && (s_r.cont || !pk_wrap))
                        begin
                            go = 1'b1;
                            go_ch = pk_nxt;
                            s_nxt.start = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.st = adcs_pkg::ST_IDLE;
        endcase

        if (go)
        begin
            s_nxt.st = adcs_pkg::ST_SAMPLE;
            s_nxt.ch = go_ch;
            s_nxt.cnt = smp_len(s_r.smp[go_ch]);
            s_nxt.req.mux_sel = go_ch;
            s_nxt.req.sample = 1'b1;
            s_nxt.req.convert = 1'b0;
        end

        // no fast clock in deep sleep: abandon any conversion
        if (deep_sleep)
        begin
            s_nxt.st = adcs_pkg::ST_IDLE;
            s_nxt.start = 1'b0;
            s_nxt.req.sample = 1'b0;
            s_nxt.req.convert = 1'b0;
        end

        s_nxt.stat = s_nxt.stat | ev;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.st <= adcs_pkg::ST_IDLE;
            s_r.lim_hi <= adcs_pkg::LIM_HI_RST;
            s_r.smp <= {adcs_pkg::NCH{adcs_pkg::SMP_RST}};
        end
        else
            s_r <= s_nxt;
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign core_req = s_r.req;
    assign core_tick = tick;
    assign irq = s_r.irq;
endmodule : adcs_seq
`default_nettype wire

/* File: tb/adcs_conv_model.sv */
// behavioural converter core answering the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module adcs_conv_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // sequencer side
    input wire adcs_pkg::adcs_core_req_s core_req,
    output adcs_pkg::adcs_core_rsp_s core_rsp,
    // scenario control: 12-bit value per input, answer delay
    input wire logic [95:0] vals,
    input wire logic [3:0] lag
);
    logic cnv_d;
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge clk_sys)
    begin
        cnv_d <= core_req.convert;
        core_rsp.valid <= 1'b0;
        if (rst)
        begin
            busy <= 1'b0;
            core_rsp.data <= 12'hA5A;
        end
        else if (cnv_d && !core_req.convert)
        begin
            busy <= 1'b1;
            cnt <= lag;
        end
        else if (busy && cnt == 4'h0)
        begin
            busy <= 1'b0;
            core_rsp.valid <= 1'b1;
            core_rsp.data <= vals[core_req.mux_sel * 12 +: 12];
        end
        else
        begin
            cnt <= cnt - 4'h1;
            // data toggles outside valid so a stale sample never matches
            core_rsp.data <= ~core_rsp.data;
        end
    end
endmodule : adcs_conv_model
`default_nettype wire

/* File: tb/adcs_seq_properties.sv */
// concurrent checks on the ports of the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module adcs_seq_properties #(
    parameter int DIV = adcs_pkg::CONV_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter core
    input wire adcs_pkg::adcs_core_req_s core_req,
    input wire logic core_tick,
    input wire adcs_pkg::adcs_core_rsp_s core_rsp,
    // power and interrupt
    input wire logic deep_sleep,
    input wire logic irq
);
    // ****************************************************************
    // helper logic
    // ****************************************************************
    logic [7:0] cnv_cnt_r;
    always_ff @(posedge clk_sys)
    begin
        if (rst || !core_req.convert)
            cnv_cnt_r <= 8'h00;
        else
            cnv_cnt_r <= cnv_cnt_r + {7'h00, core_tick};
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_access;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    sequence s_deep_held;
        deep_sleep [*3];
    endsequence
    property p_rdy_wait;
        s_access |=> pready;
    endproperty
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    property p_rdy_in;
        pready |-> psel && penable;
    endproperty
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    property p_conv_len;
        $fell(core_req.convert) && !deep_sleep && !$past(deep_sleep)
            |-> cnv_cnt_r == adcs_pkg::CONV_CLKS;
    endproperty
    property p_mux_hold;
        (core_req.sample || core_req.convert) && $past(core_req.sample || core_req.convert)
            |-> $stable(core_req.mux_sel);
    endproperty
    property p_sample_cause;
        $rose(core_req.sample) |-> $past(core_rsp.valid) || $past(core_rsp.valid, 2)
            || $past(pready) || $past(pready, 2);
    endproperty
    property p_irq_rise;
        $rose(irq) |-> $past(core_rsp.valid) || $past(core_rsp.valid, 2)
            || $past(pready) || $past(pready, 2);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(pready) || $past(pready, 2);
    endproperty
    property p_deep;
        s_deep_held |-> !core_req.sample && !core_req.convert;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait");
    a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
    a_rdy_in: assert property (p_rdy_in) else $error("pready outside access");
    a_err: assert property (p_err) else $error("pslverr without pready or zero data");
    a_conv_len: assert property (p_conv_len) else $error("convert phase length wrong");
    a_mux_hold: assert property (p_mux_hold) else $error("mux moved mid channel");
    a_sample_cause: assert property (p_sample_cause) else $error("sample start uncaused");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose uncaused");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncleared");
    a_deep: assert property (p_deep) else $error("converter active in deep sleep");
endmodule : adcs_seq_properties
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking testbench for the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int DIV = 1;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    adcs_pkg::adcs_core_req_s core_req;
    logic core_tick;
    adcs_pkg::adcs_core_rsp_s core_rsp;
    logic deep_sleep = 1'b0;
    logic irq;
    logic [95:0] vals = {12'hFFF, 12'hFFF, 12'h900, 12'hFFF, 12'hFFF, 12'h400, 12'hFFF, 12'h050};
    logic [3:0] lag = 4'h5;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int run = 0;
    logic [7:0] smp_len [8];
    logic [2:0] order [$];
    logic [31:0] q;
    logic e;
    adcs_seq #(.DIV(DIV)) i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_tick(core_tick), .core_rsp(core_rsp),
        .deep_sleep(deep_sleep), .irq(irq));
    adcs_conv_model i_core (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
        .core_rsp(core_rsp), .vals(vals), .lag(lag));
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    // sample phase length and channel order as seen at the mux
    always @(posedge clk_sys)
    begin
        if (core_req.sample && run == 0)
            order.push_back(core_req.mux_sel);
        if (core_req.sample)
            run <= run + 1;
        else if (run != 0)
        begin
            smp_len[core_req.mux_sel] <= 8'(run);
            run <= 0;
        end
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait states", 32'h2, n);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : wr
    task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask : rd
    task wait_irq(input int b);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, adcs_pkg::A_IRQ, 32'h0);
            n++;
        end
        while (q[b] !== 1'b1 && n < 300);
        chk("event bit", 32'h1, {31'h0, q[b]});
    endtask : wait_irq
    task end_sim();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_regs();
        rd("smp reset", adcs_pkg::A_SMP + 8'h0C, 32'h4);
        rd("lim reset", adcs_pkg::A_LIM, 32'h0FFF_0000);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        wr(adcs_pkg::A_SMP + 8'h04, 32'hAB);
        rd("smp rw", adcs_pkg::A_SMP + 8'h04, 32'hAB);
        chk("irq idle", 32'h0, {31'h0, irq});
    endtask : t_regs
    task t_scan();
        wr(adcs_pkg::A_LIM, 32'h0800_0100);
        wr(adcs_pkg::A_MASK, 32'h1);
        wr(adcs_pkg::A_SMP, 32'h0);
        wr(adcs_pkg::A_SMP + 8'h08, 32'h3);
        wr(adcs_pkg::A_SMP + 8'h14, 32'h7);
        wr(adcs_pkg::A_CHEN, 32'h25);
        order.delete();
        wr(adcs_pkg::A_CTRL, 32'h9);
        wait_irq(adcs_pkg::I_SCAN);
        chk("scan len", 32'h3, order.size());
        chk("order", 32'h015, {order[0], order[1], order[2]});
        chk("smp ch0", 32'h1, smp_len[0]);
        chk("smp ch2", 32'h3, smp_len[2]);
        chk("smp ch5", 32'h7, smp_len[5]);
        chk("irq range", 32'h1, {31'h0, irq});
        rd("res0", adcs_pkg::A_RES, 32'h8000_0050);
        rd("res2", adcs_pkg::A_RES + 8'h08, 32'h8000_0400);
        rd("res5", adcs_pkg::A_RES + 8'h14, 32'h8000_0900);
        rd("res1", adcs_pkg::A_RES + 8'h04, 32'h0);
        rd("res0 again", adcs_pkg::A_RES, 32'h050);
        rd("range flags", adcs_pkg::A_RFLAG, 32'h21);
        rd("irq stat", adcs_pkg::A_IRQ, 32'h7);
        chk("irq held", 32'h1, {31'h0, irq});
        wr(adcs_pkg::A_IRQ, 32'h1);
        rd("irq stat clr", adcs_pkg::A_IRQ, 32'h6);
        chk("irq clr", 32'h0, {31'h0, irq});
    endtask : t_scan
    task t_fw();
        lag <= 4'h0;
        wr(adcs_pkg::A_IRQ, 32'h7);
        wr(adcs_pkg::A_RFLAG, 32'hFF);
        order.delete();
        wr(adcs_pkg::A_CTRL, 32'h6B);
        wait_irq(adcs_pkg::I_EOC);
        chk("fw chan", 32'h6, order[0]);
        rd("res6", adcs_pkg::A_RES + 8'h18, 32'h8000_0FFF);
        rd("res0 kept", adcs_pkg::A_RES, 32'h050);
        rd("flag6", adcs_pkg::A_RFLAG, 32'h40);
    endtask : t_fw
    task t_deep();
        wr(adcs_pkg::A_CTRL, 32'hD);
        repeat (30) @(posedge clk_sys);
        deep_sleep <= 1'b1;
        repeat (5) @(posedge clk_sys);
        apb(1'b0, adcs_pkg::A_STAT, 32'h0);
        chk("deep status", 32'h10, q & 32'h11);
        wr(adcs_pkg::A_CTRL, 32'hD);
        repeat (5) @(posedge clk_sys);
        chk("deep sample", 32'h0, {31'h0, core_req.sample});
        deep_sleep <= 1'b0;
        wr(adcs_pkg::A_CTRL, 32'h0);
    endtask : t_deep
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_scan();
        t_fw();
        t_deep();
        end_sim();
    end
endmodule : testbench
bind adcs_seq adcs_seq_properties #(.DIV(DIV)) i_props (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(core_req),
    .core_tick(core_tick), .core_rsp(core_rsp), .deep_sleep(deep_sleep), .irq(irq));
`default_nettype wire
